/* File: rtl/pog_pkg.sv */
// How it works
// - Trigger rising edge starts pulse; inverted output is its complement.
// - Width is inherent width plus 22-bit code times increment.
// - Abort input ends an active pulse at once.
// - Low 6 code bits give fine steps; high 16 bits drive oscillator count.
// - Code zero gives the shortest, inherent width.
// - Above 15 ns increment, fine bits ignored; step is 64 increments.
// - Triggers during a pulse are ignored; no restart or extension.
// - After natural end, triggers ignored for a short recovery time.
// - After abort, triggers ignored for a short recovery time.
// - Increment is a build parameter from 0.25 ns to 50 ns.
// - Window high: each shift clock rise shifts data in, MSB first.
// - Window falling edge loads code; applies from next trigger.
// - Old register contents shift out MSB first for chaining.
`default_nettype none

package pog_pkg;

  // Timing base, all in picoseconds
  localparam int unsigned CLK_PS = 10000;
  localparam int unsigned INC_MIN_PS = 250;
  localparam int unsigned INC_MAX_PS = 50000;
  localparam int unsigned INC_DEF_PS = 1000;
  localparam int unsigned INH_DEF_PS = 10000;
  localparam int unsigned FINE_LIMIT_PS = 15000;
  localparam int unsigned RECOVER_PS = 3000;
  // Least time rounds up, at least one cycle
  localparam int unsigned RECOVER_CYC_RAW = (RECOVER_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned RECOVER_CYC = (RECOVER_CYC_RAW < 1) ? 1 : RECOVER_CYC_RAW;

  // Code layout
  localparam int CODE_W = 22;
  localparam int FINE_W = 6;
  localparam int COARSE_W = 16;
  localparam int FINE_LSB = 0;
  localparam int COARSE_LSB = FINE_W;
  localparam int FINE_STEPS = 64;
  localparam logic [CODE_W-1:0] CODE_RESET = 22'h000000;

  // Time accumulator and recovery counter widths
  localparam int PS_W = 32;
  localparam int REC_W = 8;

  // Sync lanes
  localparam int SYNC_W = 3;
  localparam int LANE_TRIGGER_IN = 0;
  localparam int LANE_ABORT = 1;
  localparam int LANE_WIN = 2;

  // Gray codes along idle, coarse, fine, recover
  typedef enum logic [1:0] {
    POG_IDLE = 2'h0,
    POG_COARSE = 2'h1,
    POG_FINE = 2'h3,
    POG_RECOVER = 2'h2
  } pog_state_e;

endpackage

`default_nettype wire

/* File: rtl/pog_sync.sv */
`default_nettype none

// Three-stage synchroniser; output moves only when stages two and three agree
module pog_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] ff1_reg;
  logic [W-1:0] ff2_reg;
  logic [W-1:0] ff3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;

  // Per-lane agreement filter on stages two and three
  always_comb begin
    out_next = out_reg;
    for (int i = 0; i < W; i++) begin
      if (ff2_reg[i] == ff3_reg[i]) begin
        out_next[i] = ff3_reg[i];
      end
    end
  end

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ff1_reg <= '0;
      ff2_reg <= '0;
      ff3_reg <= '0;
      out_reg <= '0;
    end else begin
      ff1_reg <= async_in;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;

endmodule

`default_nettype wire

/* File: rtl/pog_step_osc.sv */
`default_nettype none

// Coarse oscillator: one tick each time STEP_PS of time has run
module pog_step_osc
  import pog_pkg::*;
#(
  parameter int unsigned STEP_PS = FINE_STEPS * INC_DEF_PS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  output logic tick
);

  localparam logic [PS_W-1:0] STEP = PS_W'(STEP_PS);
  localparam logic [PS_W-1:0] CLK_STEP = PS_W'(CLK_PS);

  logic [PS_W-1:0] acc_reg;
  logic [PS_W-1:0] acc_next;
  logic tick_reg;
  logic tick_next;
  logic [PS_W-1:0] sum;

  // Residual kept so long counts do not drift; step is never below one clock
  always_comb begin
    sum = acc_reg + CLK_STEP;
    acc_next = sum;
    tick_next = 1'b0;
    if (!run) begin
      acc_next = '0;
    end else if (sum >= STEP) begin
      acc_next = sum - STEP;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule

`default_nettype wire

/* File: rtl/pog_oneshot.sv */
`default_nettype none

// Retrigger-protected one-shot with serial width loading
module pog_oneshot
  import pog_pkg::*;
#(
  parameter int unsigned INC_PS = INC_DEF_PS,
  parameter int unsigned INH_PS = INH_DEF_PS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic trigger_in,
  input wire logic pulse_abort_in,
  output logic pulse_out,
  output logic pulse_out_inverted,
  input wire logic shift_clock,
  input wire logic load_window,
  input wire logic shift_data_in,
  output logic shift_data_out
);

  // Fine cells usable only at small increments
  localparam bit FINE_OK = (INC_PS <= FINE_LIMIT_PS);
  localparam logic [PS_W-1:0] INH = PS_W'(INH_PS);
  localparam logic [PS_W-1:0] INC = PS_W'(INC_PS);
  localparam logic [PS_W-1:0] CLK_STEP = PS_W'(CLK_PS);
  localparam logic [REC_W-1:0] REC_LOAD = REC_W'(RECOVER_CYC);
  localparam logic [REC_W-1:0] REC_ONE = REC_W'(1);
  localparam logic [COARSE_W-1:0] CNT_ONE = COARSE_W'(1);

  // ---------------- Link domain (shift_clock) ----------------

  logic [CODE_W-1:0] shift_reg;
  logic [CODE_W-1:0] shift_next;

  always_comb begin
    shift_next = shift_reg;
    if (load_window) begin
      shift_next = {shift_reg[CODE_W-2:0], shift_data_in};
    end
  end

  // Clock stands still between frames, so nothing here waits on an edge
  always_ff @(posedge shift_clock or negedge rstn) begin
    if (!rstn) begin
      shift_reg <= CODE_RESET;
    end else begin
      shift_reg <= shift_next;
    end
  end

  assign shift_data_out = shift_reg[CODE_W-1];

  // ---------------- Pin synchronisers ----------------

  logic [SYNC_W-1:0] pins_sync;

  pog_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in({load_window, pulse_abort_in, trigger_in}),
    .sync_out(pins_sync)
  );

  logic trigger_in_lvl;
  logic abort_lvl;
  logic win_lvl;
  assign trigger_in_lvl = pins_sync[LANE_TRIGGER_IN];
  assign abort_lvl = pins_sync[LANE_ABORT];
  assign win_lvl = pins_sync[LANE_WIN];

  // ---------------- Code load (clk domain) ----------------

  logic trigger_in_prev_reg;
  logic win_prev_reg;
  logic [CODE_W-1:0] code_reg;
  logic [CODE_W-1:0] code_next;
  logic trigger_in_rise;
  logic win_fall;

  assign trigger_in_rise = trigger_in_lvl & ~trigger_in_prev_reg;
  assign win_fall = win_prev_reg & ~win_lvl;

  always_comb begin
    code_next = code_reg;
    if (win_fall) begin
      // Shift register is quiet once the window is low, so the word is stable
      code_next = shift_reg;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trigger_in_prev_reg <= 1'b0;
      win_prev_reg <= 1'b0;
      code_reg <= CODE_RESET;
    end else begin
      trigger_in_prev_reg <= trigger_in_lvl;
      win_prev_reg <= win_lvl;
      code_reg <= code_next;
    end
  end

  // ---------------- Width split ----------------

  logic [FINE_W-1:0] fine_code;
  logic [COARSE_W-1:0] coarse_code;
  logic [PS_W-1:0] fine_budget;

  assign coarse_code = code_reg[COARSE_LSB +: COARSE_W];
  // fine bits dropped at large increments
  assign fine_code = FINE_OK ? code_reg[FINE_LSB +: FINE_W] : '0;
  assign fine_budget = INH + PS_W'(fine_code) * INC;

  // ---------------- Coarse oscillator ----------------

  logic osc_tick;
  pog_state_e state_reg;
  pog_state_e state_next;

  pog_step_osc #(
    .STEP_PS(FINE_STEPS * INC_PS)
  ) u_osc (
    .clk(clk),
    .rstn(rstn),
    .run(state_reg == POG_COARSE),
    .tick(osc_tick)
  );

  // ---------------- Pulse sequencer ----------------

  logic [COARSE_W-1:0] cnt_reg;
  logic [COARSE_W-1:0] cnt_next;
  logic [PS_W-1:0] fine_reg;
  logic [PS_W-1:0] fine_next;
  logic [REC_W-1:0] rec_reg;
  logic [REC_W-1:0] rec_next;
  logic pulse_reg;
  logic pulse_next;
  logic pulse_n_reg;

  // Next state, counters and output level
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    fine_next = fine_reg;
    rec_next = rec_reg;
    pulse_next = pulse_reg;
    unique case (state_reg)
      POG_IDLE: begin
        if (trigger_in_rise && !abort_lvl) begin
          pulse_next = 1'b1;
          cnt_next = coarse_code;
          fine_next = fine_budget;
          state_next = (coarse_code == '0) ? POG_FINE : POG_COARSE;
        end
      end
      POG_COARSE: begin
        if (abort_lvl) begin
          pulse_next = 1'b0;
          rec_next = REC_LOAD;
          state_next = POG_RECOVER;
        end else if (osc_tick) begin
          cnt_next = cnt_reg - CNT_ONE;
          if (cnt_reg == CNT_ONE) begin
            state_next = POG_FINE;
          end
        end
      end
      POG_FINE: begin
        if (abort_lvl) begin
          pulse_next = 1'b0;
          rec_next = REC_LOAD;
          state_next = POG_RECOVER;
        end else if (fine_reg <= CLK_STEP) begin
          pulse_next = 1'b0;
          rec_next = REC_LOAD;
          state_next = POG_RECOVER;
        end else begin
          fine_next = fine_reg - CLK_STEP;
        end
      end
      POG_RECOVER: begin
        if (rec_reg <= REC_ONE) begin
          state_next = POG_IDLE;
        end else begin
          rec_next = rec_reg - REC_ONE;
        end
      end
    endcase
  end

  // triggers outside idle are ignored by the sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= POG_IDLE;
      cnt_reg <= '0;
      fine_reg <= '0;
      rec_reg <= '0;
      pulse_reg <= 1'b0;
      pulse_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      fine_reg <= fine_next;
      rec_reg <= rec_next;
      pulse_reg <= pulse_next;
      pulse_n_reg <= ~pulse_next;
    end
  end

  assign pulse_out = pulse_reg;
  assign pulse_out_inverted = pulse_n_reg;

endmodule

`default_nettype wire

/* File: sim/pog_oneshot_sva.sv */
`default_nettype none
module pog_oneshot_sva (
  input wire logic clk,
  input wire logic rstn,
  input wire logic trigger_in,
  input wire logic pulse_abort_in,
  input wire logic pulse_out,
  input wire logic pulse_out_inverted,
  input wire logic shift_clock,
  input wire logic load_window,
  input wire logic shift_data_in,
  input wire logic shift_data_out
);
  logic [4:0] run_reg;
  logic [4:0] run_next;
  // Shift edges in a row with window high; saturates so it never wraps
  always_comb begin
    run_next = 5'h00;
    if (load_window) begin
      run_next = (run_reg == 5'h1f) ? run_reg : run_reg + 5'h01;
    end
  end
  always_ff @(posedge shift_clock or negedge rstn) begin
    if (!rstn) begin
      run_reg <= 5'h00;
    end else begin
      run_reg <= run_next;
    end
  end
  a_out_complement: assert property (@(posedge clk) disable iff (!rstn)
    pulse_out_inverted != pulse_out) else $error("outputs not complementary");
  a_start_has_cause: assert property (@(posedge clk) disable iff (!rstn) $rose(pulse_out) |->
    ($past(trigger_in, 3) || $past(trigger_in, 4) || $past(trigger_in, 5) || $past(trigger_in, 6)))
    else $error("pulse began without trigger");
  a_start_on_time: assert property (@(posedge clk) disable iff (!rstn)
    (!pulse_abort_in && !pulse_out)[*5] ##1 ($rose(trigger_in) && !pulse_abort_in) |-> ##[3:7] pulse_out)
    else $error("idle trigger gave no pulse");
  a_abort_ends_pulse: assert property (@(posedge clk) disable iff (!rstn)
    $rose(pulse_abort_in) && pulse_out |-> ##[1:7] !pulse_out) else $error("abort did not end pulse");
  a_abort_blocks_start: assert property (@(posedge clk) disable iff (!rstn)
    pulse_abort_in[*6] |=> !$rose(pulse_out)) else $error("pulse began during abort");
  a_recovery_gap: assert property (@(posedge clk) disable iff (!rstn)
    $fell(pulse_out) |=> !pulse_out) else $error("no recovery after pulse");
  a_reset_idle: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> !pulse_out && pulse_out_inverted) else $error("outputs not idle after reset");
  a_shift_chain: assert property (@(posedge shift_clock) disable iff (!rstn)
    run_reg >= 5'h16 |-> shift_data_out == $past(shift_data_in, 22)) else $error("serial out not 22 behind");
endmodule

bind pog_oneshot pog_oneshot_sva u_sva (.clk(clk), .rstn(rstn), .trigger_in(trigger_in),
  .pulse_abort_in(pulse_abort_in), .pulse_out(pulse_out), .pulse_out_inverted(pulse_out_inverted),
  .shift_clock(shift_clock), .load_window(load_window), .shift_data_in(shift_data_in),
  .shift_data_out(shift_data_out));
`default_nettype wire

/* File: sim/pog_ctl.sv */
`default_nettype none
module pog_ctl (
  input wire logic clk,
  input wire logic shift_data_out,
  output logic trigger_in,
  output logic pulse_abort_in,
  output logic shift_clock,
  output logic load_window,
  output logic shift_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle levels; link clock stands still outside frames
  initial begin
    trigger_in = 1'h0;
    pulse_abort_in = 1'h0;
    shift_clock = 1'h0;
    load_window = 1'h0;
    shift_data_in = 1'h0;
  end
  // Held three cycles so the synchroniser surely sees it
  task automatic fire();
    trigger_in <= 1'h1;
    repeat (3) @(posedge clk);
    trigger_in <= 1'h0;
  endtask
  task automatic abort();
    pulse_abort_in <= 1'h1;
    repeat (7) @(posedge clk);
    pulse_abort_in <= 1'h0;
  endtask
  task automatic load(input logic [21:0] code, output logic [21:0] seen);
    #7 load_window = 1'h1;
    for (int i = 21; i >= 0; i--) begin
      shift_data_in = code[i];
      #15 seen[i] = shift_data_out;
      shift_clock = 1'h1;
      #15 shift_clock = 1'h0;
    end
    #10 load_window = 1'h0;
    shift_data_in = ~code[0];
    #100;
  endtask
endmodule
`default_nettype wire

/* File: sim/pog_oneshot_test.sv */
`default_nettype none
module pog_oneshot_test import pog_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned INC = 1000;
  localparam int unsigned INH = 10000;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic trigger_in, pulse_abort_in, pulse_out, pulse_out_inverted;
  logic shift_clock, load_window, shift_data_in, shift_data_out;
  logic [CODE_W-1:0] held = CODE_RESET;
  int fails = 0;
  int n_tests = 0;
  int lo_q[$];
  int hi_q[$];
  always #5 clk = ~clk;
  pog_ctl ctl (.clk(clk), .shift_data_out(shift_data_out), .trigger_in(trigger_in),
    .pulse_abort_in(pulse_abort_in), .shift_clock(shift_clock), .load_window(load_window),
    .shift_data_in(shift_data_in));
  pog_oneshot #(.INC_PS(INC), .INH_PS(INH)) DUT (.clk(clk), .rstn(rstn), .trigger_in(trigger_in),
    .pulse_abort_in(pulse_abort_in), .pulse_out(pulse_out), .pulse_out_inverted(pulse_out_inverted),
    .shift_clock(shift_clock), .load_window(load_window), .shift_data_in(shift_data_in),
    .shift_data_out(shift_data_out));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  function automatic int fine_w(input int f);
    return (INH + f * INC + CLK_PS - 1) / CLK_PS;
  endfunction
  task automatic load(input logic [CODE_W-1:0] code);
    logic [CODE_W-1:0] seen;
    ctl.load(code, seen);
    chk(32'(seen), 32'(held));
    held = code;
  endtask
  // Note the width window, fire, then wait out pulse and recovery
  task automatic run(input int lo, input int hi, input bit retrig);
    lo_q.push_back(lo);
    hi_q.push_back(hi);
    @(posedge clk);
    ctl.fire();
    if (retrig) begin
      repeat (15) @(posedge clk);
      ctl.fire();
    end
    for (int i = 0; i < 3000 && lo_q.size() > 0; i++) @(posedge clk);
    repeat (6) @(posedge clk);
  endtask
  // Width monitor, sampled on the falling edge where outputs are settled
  initial begin : monitor
    int w;
    int lo;
    int hi;
    forever begin
      @(posedge pulse_out);
      w = 0;
      @(negedge clk);
      while (pulse_out === 1'h1) begin
        w++;
        @(negedge clk);
      end
      lo = (lo_q.size() > 0) ? lo_q.pop_front() : 0;
      hi = (hi_q.size() > 0) ? hi_q.pop_front() : 0;
      // Inside the window the width stands; outside, the low bound is what was due
      chk(32'(w), 32'((w >= lo && w <= hi) ? w : lo));
    end
  end
  initial begin
    #100000;
    fails++;
    stop_test();
  end
  initial begin : main
    int f;
    int c;
    void'($urandom(74362));
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    @(negedge clk);
    chk(32'(pulse_out), 32'h0);
    chk(32'(pulse_out_inverted), 32'h1);
    run(fine_w(0), fine_w(0), 1'b0);
    for (int i = 0; i < 4; i++) begin
      f = (i == 0) ? 63 : $urandom_range(62, 1);
      load(CODE_W'(f));
      run(fine_w(f), fine_w(f), 1'b0);
    end
    c = $urandom_range(20, 8);
    f = $urandom_range(63);
    load(CODE_W'(c * FINE_STEPS + f));
    run(c * FINE_STEPS * INC / CLK_PS + fine_w(f), c * FINE_STEPS * INC / CLK_PS + fine_w(f) + 3, 1'b1);
    load(CODE_W'(100 * FINE_STEPS));
    lo_q.push_back(29);
    hi_q.push_back(31);
    @(posedge clk);
    ctl.fire();
    repeat (27) @(posedge clk);
    ctl.abort();
    repeat (8) @(posedge clk);
    load(CODE_RESET);
    run(fine_w(0), fine_w(0), 1'b0);
    chk(32'(lo_q.size()), 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
